// ==== src/xcbt_pkg.sv ====
// Package for the board-test chain controller: codes and timing counts.
// Assumes a 100 MHz core clock.
package xcbt_pkg;
    localparam int          CHAIN_W         = 24;
    localparam logic [2:0]  SEL_ARM         = 3'h1;
    localparam logic [2:0]  SEL_GO          = 3'h7;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          STEP_MIN_NS     = 1000;
    // Least time rounds up
    localparam int          STEP_MIN_CYC    = (STEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W           = 8;
    localparam logic [CNT_W-1:0] STEP_MIN_CNT = CNT_W'(STEP_MIN_CYC);
    localparam int          SYNC_W          = 3;
endpackage : xcbt_pkg

// ==== src/xcbt_sync.sv ====
// Three-flop synchroniser bank with agreement filter on last two stages.
// Assumes inputs asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module xcbt_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    wire  [W-1:0] agree = ~(s2_r ^ s3_r);
    wire  [W-1:0] out_nxt = (agree & s3_r) | (~agree & sync_out);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s1_r     <= '0;
            s2_r     <= '0;
            s3_r     <= '0;
            sync_out <= '0;
        end
        else if (clk_en)
        begin
            s1_r     <= async_in;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            sync_out <= out_nxt;
        end
    end
endmodule : xcbt_sync
`default_nettype wire

// ==== src/xcbt_top.sv ====
// Board-test chain controller: entry sequencer, pin detach and XNOR result.
// Assumes pins arrive unsynchronised; rst is the core's own synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module xcbt_top (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        clk_en,
    input  wire logic                        chip_reset_n,
    input  wire logic                        test_pin,
    input  wire logic [2:0]                  lad_low,
    input  wire logic                        lad_top,
    input  wire logic [xcbt_pkg::CHAIN_W-2:0] chain_pins,
    input  wire logic                        func_warn,
    output logic                             chain_result_pin,
    output logic                             chain_active,
    output logic [xcbt_pkg::CHAIN_W-1:0]     func_pins
);
    typedef enum logic [4:0] {
        XC_IDLE  = 5'h01,
        XC_ARMED = 5'h02,
        XC_TEST  = 5'h04,
        XC_CHAIN = 5'h08,
        XC_FAIL  = 5'h10
    } xcbt_state_t;

    // Even-parity style XNOR reduction; all-low gives low
    function automatic logic xcbt_xnor(input logic [xcbt_pkg::CHAIN_W-1:0] v);
        logic acc;
        acc = 1'b1;
        for (int i = 0; i < xcbt_pkg::CHAIN_W; i++)
        begin
            acc = ~(acc ^ v[i]);
        end
        return acc ^ (xcbt_pkg::CHAIN_W % 2 == 0 ? 1'b1 : 1'b0);
    endfunction : xcbt_xnor

    logic [xcbt_pkg::CHAIN_W+4:0] sy;
    logic                         in_rst_n;
    logic                         in_test;
    logic [2:0]                   in_sel;
    logic [xcbt_pkg::CHAIN_W-1:0] in_chain;
    xcbt_state_t                  state_r;
    xcbt_state_t                  state_nxt;
    logic [xcbt_pkg::CNT_W-1:0]   dwell_r;
    logic [xcbt_pkg::CNT_W-1:0]   dwell_nxt;
    logic [2:0]                   sel_prev_r;
    logic                         test_prev_r;

    // Excluded pins never enter the vector; top LAD does
    xcbt_sync #(.W(xcbt_pkg::CHAIN_W + 5)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in ({chip_reset_n, test_pin, lad_low, lad_top, chain_pins}),
        .sync_out (sy)
    );

    assign in_rst_n = sy[xcbt_pkg::CHAIN_W+4];
    assign in_test  = sy[xcbt_pkg::CHAIN_W+3];
    assign in_sel   = sy[xcbt_pkg::CHAIN_W+2:xcbt_pkg::CHAIN_W];
    assign in_chain = sy[xcbt_pkg::CHAIN_W-1:0];

    wire sel_moved  = (in_sel != sel_prev_r) || (in_test != test_prev_r);
    wire dwell_ok   = (dwell_r >= xcbt_pkg::STEP_MIN_CNT);
    wire chain_bit  = xcbt_xnor(in_chain);

    // Outputs follow the next mode so that all of them switch on one edge;
    // a pin is never seen detached while the result still shows the warning
    wire                         chain_nxt  = (state_nxt == XC_CHAIN);
    wire                         result_nxt = chain_nxt ? chain_bit : func_warn;
    wire [xcbt_pkg::CHAIN_W-1:0] func_nxt   = chain_nxt ? '0 : in_chain;

    // Dwell counter measures time since the last step change
    assign dwell_nxt = sel_moved ? '0 : (dwell_ok ? dwell_r : dwell_r + 1'b1);

    // Entry sequencer: each step only from its predecessor
    always_comb
    begin
        state_nxt = state_r;
        if (!in_rst_n)
        begin
            state_nxt = XC_IDLE;
        end
        else
        begin
            unique case (state_r)
                XC_IDLE:
                begin
                    if (in_test)
                        state_nxt = XC_FAIL;
                    else if (in_sel == xcbt_pkg::SEL_ARM)
                        state_nxt = XC_ARMED;
                end
                XC_ARMED:
                begin
                    if (in_sel != xcbt_pkg::SEL_ARM)
                        state_nxt = XC_FAIL;
                    else if (in_test && dwell_ok)
                        state_nxt = XC_TEST;
                end
                XC_TEST:
                begin
                    if (!in_test)
                        state_nxt = XC_FAIL;
                    else if (in_sel == xcbt_pkg::SEL_GO && dwell_ok)
                        state_nxt = XC_CHAIN;
                    else if (in_sel != xcbt_pkg::SEL_ARM)
                        state_nxt = XC_FAIL;
                end
                XC_CHAIN:
                begin
                    state_nxt = XC_CHAIN;
                end
                XC_FAIL:
                begin
                    // Held until chip reset drops or rst; no retry until then
                    state_nxt = XC_FAIL;
                end
                default:
                begin
                    state_nxt = XC_IDLE;
                end
            endcase
        end
    end

    // Mode register; rst and a low chip reset both land in idle
    // Fail is left only through idle, never straight back to an entry step
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_r <= XC_IDLE;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
        end
    end

    // Saturating dwell count; eight bits are plenty for the step gap
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            dwell_r <= '0;
        end
        else if (clk_en)
        begin
            dwell_r <= dwell_nxt;
        end
    end

    // Last step code, to see when the tester moves to the next step
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sel_prev_r  <= 3'h0;
            test_prev_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sel_prev_r  <= in_sel;
            test_prev_r <= in_test;
        end
    end

    // Result pin is given over to the chain in chain mode
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            chain_result_pin <= 1'b0;
        end
        else if (clk_en)
        begin
            chain_result_pin <= result_nxt;
        end
    end

    // Mode flag for the rest of the chip; it rises on the same edge
    // as the pins are detached
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            chain_active <= 1'b0;
        end
        else if (clk_en)
        begin
            chain_active <= chain_nxt;
        end
    end

    // Normal functions see zeros while detached, so no stray edge reaches them
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            func_pins <= '0;
        end
        else if (clk_en)
        begin
            func_pins <= func_nxt;
        end
    end
endmodule : xcbt_top
`default_nettype wire

// ==== testbench/xcbt_asserts.sv ====
// Port checker for the chain controller.
// Assumes one clock, bound to xcbt_top.
`timescale 1ns/1ps
`default_nettype none
module xcbt_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic chip_reset_n,
    input wire logic test_pin,
    input wire logic [2:0] lad_low,
    input wire logic lad_top,
    input wire logic [22:0] chain_pins,
    input wire logic func_warn,
    input wire logic chain_result_pin,
    input wire logic chain_active,
    input wire logic [23:0] func_pins
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire [23:0] v = {lad_top, chain_pins};
    // Eight quiet cycles cover the synchroniser and output stage
    sequence s_on; (chain_active && clk_en && $stable(v))[*8]; endsequence
    sequence s_off; (!chain_active && clk_en && $stable(v))[*8]; endsequence
    property p_det; chain_active |-> func_pins == 24'h0; endproperty
    property p_par; s_on |-> chain_result_pin == ^v; endproperty
    property p_low; (chain_active && clk_en && v == 24'h0)[*8] |-> !chain_result_pin; endproperty
    property p_nrm; (!chain_active && clk_en)[*3] |-> chain_result_pin == $past(func_warn);
    endproperty
    property p_ext; (!chip_reset_n && clk_en)[*8] |-> !chain_active; endproperty
    property p_ent; $rose(chain_active) |-> test_pin && lad_low == xcbt_pkg::SEL_GO;
    endproperty
    property p_sty; (chain_active && chip_reset_n && clk_en)[*8] |=> chain_active; endproperty
    property p_pas; s_off |-> func_pins == v; endproperty
    a_det: assert property (p_det) else $error("pins kept");
    a_par: assert property (p_par) else $error("parity");
    a_low: assert property (p_low) else $error("not low");
    a_nrm: assert property (p_nrm) else $error("warn pin");
    a_ext: assert property (p_ext) else $error("no exit");
    a_ent: assert property (p_ent) else $error("entry");
    a_sty: assert property (p_sty) else $error("dropped");
    a_pas: assert property (p_pas) else $error("pass");
endmodule : xcbt_chk
bind xcbt_top xcbt_chk chk_u (.core_clk, .rst, .clk_en, .chip_reset_n, .test_pin, .lad_low,
    .lad_top, .chain_pins, .func_warn, .chain_result_pin, .chain_active, .func_pins);
`default_nettype wire

// ==== testbench/xcbt_tester.sv ====
// Board tester model: entry pins and chain inputs.
// Assumes its tasks are called at falling edges.
`timescale 1ns/1ps
`default_nettype none
module xcbt_tester (
    input wire logic core_clk,
    output logic chip_reset_n = 1'b0,
    output logic test_pin = 1'b0,
    output logic [2:0] lad_low = 3'h0,
    output logic [23:0] vec = 24'h0
);
    // Margin over the dwell; exactly 100 would leave the counter one short
    localparam int GAP = 110;
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wt
    task automatic enter(input logic [2:0] arm);
        chip_reset_n = 1'b1;
        wt(GAP);
        lad_low = arm;
        wt(GAP);
        test_pin = 1'b1;
        wt(GAP);
        lad_low = xcbt_pkg::SEL_GO;
        wt(GAP);
        vec = 24'h0;
        wt(GAP);
    endtask : enter
    task automatic leave();
        chip_reset_n = 1'b0;
        test_pin = 1'b0;
        lad_low = 3'h0;
        wt(20);
    endtask : leave
    task automatic flip(input int b);
        vec[b] = ~vec[b];
    endtask : flip
endmodule : xcbt_tester
`default_nettype wire

// ==== testbench/xcbt_top_bench.sv ====
// Self-checking bench with a parity model.
// Assumes the tester model and bound checker.
`timescale 1ns/1ps
`default_nettype none
module xcbt_top_bench;
    logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, func_warn = 1'b0;
    logic chip_reset_n, test_pin, res, act;
    logic [2:0] lad_low;
    logic [23:0] vec, fp;
    int error_cnt = 0, comparisons = 0, cyc = 0, par = 0;
    int q[$];
    xcbt_tester tst_u (.core_clk, .chip_reset_n, .test_pin, .lad_low, .vec);
    xcbt_top dut_u (.core_clk, .rst, .clk_en, .chip_reset_n, .test_pin, .lad_low,
        .lad_top(vec[23]), .chain_pins(vec[22:0]), .func_warn, .chain_result_pin(res),
        .chain_active(act), .func_pins(fp));
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            results();
        end
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    initial
    begin
        void'($urandom(32'h7935));
        func_warn = 1'($urandom);
        tst_u.wt(5);
        rst = 1'b0;
        for (int i = 0; i < 24; i++)
            q.push_back(i);
        repeat (8) q.push_back($urandom_range(23));
        tst_u.flip($urandom_range(23));
        tst_u.wt(10);
        chk(fp, vec);
        chk(24'(res), 24'(func_warn));
        func_warn = ~func_warn;
        tst_u.wt(3);
        chk(24'(res), 24'(func_warn));
        tst_u.enter(3'h2);
        chk(24'(act), 24'h0);
        tst_u.leave();
        tst_u.enter(xcbt_pkg::SEL_ARM);
        chk(24'(act), 24'h1);
        chk(24'(res), 24'h0);
        chk(fp, 24'h0);
        // The warning input must not reach the pin while it carries the chain
        func_warn = ~func_warn;
        tst_u.wt(3);
        chk(24'(res), 24'h0);
        foreach (q[k])
        begin
            tst_u.flip(q[k]);
            par ^= 1;
            tst_u.wt(10);
            chk(24'(res), 24'(par));
        end
        // A low clock enable holds the result; the flip shows once it is high
        clk_en = 1'b0;
        tst_u.flip(q[0]);
        tst_u.wt(10);
        chk(24'(res), 24'(par));
        clk_en = 1'b1;
        par ^= 1;
        tst_u.wt(10);
        chk(24'(res), 24'(par));
        chk(fp, 24'h0);
        // Core reset in chain mode: with the test pin still high the
        // sequencer must not re-enter, and the pins return to normal use
        rst = 1'b1;
        tst_u.wt(5);
        rst = 1'b0;
        tst_u.wt(20);
        chk(24'(act), 24'h0);
        chk(fp, vec);
        tst_u.leave();
        tst_u.enter(xcbt_pkg::SEL_ARM);
        par = 0;
        chk(24'(act), 24'h1);
        chk(24'(res), 24'(par));
        tst_u.leave();
        chk(24'(act), 24'h0);
        chk(24'(res), 24'(func_warn));
        results();
    end
endmodule : xcbt_top_bench
`default_nettype wire
